// ===== hdl/ftfc_pkg.sv
// ----------------------------------------------------------------------------
// How it works
// - Flush-to-zero clear: denormal operand raises unimplemented; tiny result too, unless flush-to-nearest (final result) or flush override (product) is set.
// - Flush-to-zero set: denormal operands become zero, tiny results zero or smallest normal.
// - Flush override set: tiny fused product ignores flush-to-zero; product step only.
// - Flush override set: tiny product kept unbounded, never forced; its flush step never traps.
// - Override clear, flush-to-zero set: product takes untrapped default; both clear: unimplemented.
// - Flush-to-nearest in nearest mode: below half smallest normal gives zero, else smallest normal.
// - Flush-to-nearest wins over flush-to-zero for tiny final results.
// - Flush-to-nearest in other rounding modes behaves as flush-to-zero for final results.
// - Flush-to-nearest clear, flush-to-zero set: final tiny result takes untrapped default.
// - Any control word move checks enables against cause and may raise a trap.
// - Ordinary op: round unbounded, then substitute default on overflow or affected tiny.
// - Cause updates every step; enabled exception traps at once, later steps skipped.
// - Rounding priority unimplemented, invalid, divide-by-zero, then under/overflow; exclusive except invalid+inexact.
// - Rounding step never sets underflow with overflow; range exit sets one.
// - Flushing step sets inexact whenever it substitutes a default result.
// - Fused op runs round product, flush product, round sum, flush sum.
// - Fused op may end with product underflow plus sum overflow both set.
// - Flush-to-zero set: denormal operand in a rounding step sets inexact, except when unimplemented or divide-by-zero is raised.
// - Operand conditions show in the step using the operand; addend in sum rounding.
// - Unimplemented clears earlier cause updates; only it stays set on that trap.
// - Trap when cause and matching enable both set; unimplemented always enabled.
// - Rounding mode 0 nearest even, 1 toward zero, 2 plus infinity, 3 minus infinity.
// ----------------------------------------------------------------------------
package ftfc_pkg;
  // --------------------------------------------------------------------------
  // Register map and field layout
  // --------------------------------------------------------------------------
  localparam int FTFC_AW = 12;
  localparam logic [FTFC_AW-1:0] FTFC_CSR_OFS = 12'h000;
  localparam logic [FTFC_AW-1:0] FTFC_STATUS_OFS = 12'h004;
  localparam logic [FTFC_AW-1:0] FTFC_MODE_OFS = 12'h008;
  localparam int FTFC_RM_LSB = 0;
  localparam int FTFC_FLAGS_LSB = 2;
  localparam int FTFC_EN_LSB = 7;
  localparam int FTFC_CAUSE_LSB = 12;
  localparam int FTFC_FLUSH_NEAR_BIT = 21;
  localparam int FTFC_FLUSH_OVR_BIT = 22;
  localparam int FTFC_FLUSH_ZERO_BIT = 24;
  localparam logic [31:0] FTFC_CSR_RST = 32'h0000_0000;
  // Cause vector positions; the low five match the enable and flag fields
  localparam int FTFC_CB_I = 0;
  localparam int FTFC_CB_U = 1;
  localparam int FTFC_CB_O = 2;
  localparam int FTFC_CB_Z = 3;
  localparam int FTFC_CB_V = 4;
  localparam int FTFC_CB_E = 5;
  localparam logic [5:0] FTFC_CAUSE_E_ONLY = 6'h20;
  // Status register positions
  localparam int FTFC_ST_BUSY = 0;
  localparam int FTFC_ST_TRAP = 1;
  localparam int FTFC_ST_CLS_LSB = 2;
  localparam int FTFC_ST_SIGN = 5;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FTFC_RM_NEAREST = 2'h0,
    FTFC_RM_ZERO = 2'h1,
    FTFC_RM_PLUS = 2'h2,
    FTFC_RM_MINUS = 2'h3
  } ftfc_rm_t;
  typedef enum logic [2:0] {
    FTFC_RES_KEEP, FTFC_RES_ZERO, FTFC_RES_MIN_NORMAL, FTFC_RES_OVF_DEFAULT, FTFC_RES_INTERNAL
  } ftfc_cls_t;
  typedef enum {FTFC_IDLE, FTFC_RND_A, FTFC_FLS_A, FTFC_RND_B, FTFC_FLS_B} ftfc_state_t;
  // Conditions the arithmetic reports for one rounding step and its flush
  typedef struct packed {
    logic affected;
    logic denorm_in;
    logic unimpl;
    logic invalid;
    logic div_zero;
    logic inexact;
    logic ovf;
    logic tiny;
    logic below_half;
    logic sign;
  } ftfc_step_t;
  typedef struct packed {
    logic fma;
    ftfc_step_t step_a;
    ftfc_step_t step_b;
  } ftfc_req_t;
  typedef struct packed {
    ftfc_cls_t cls;
    logic sign;
  } ftfc_res_t;
  typedef struct packed {
    ftfc_rm_t rm;
    logic flush_zero_ctl;
    logic flush_override;
    logic flush_nearest_ctl;
    logic [4:0] enables;
  } ftfc_ctl_t;
  typedef struct packed {
    logic [5:0] cause;
    ftfc_cls_t cls;
  } ftfc_flush_t;
endpackage : ftfc_pkg

// ===== hdl/ftfc_core.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ftfc_core
  import ftfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FTFC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire ftfc_req_t op_req,
  output logic op_ready,
  output logic op_done,
  output logic op_trap,
  output logic move_trap,
  output ftfc_res_t op_res
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] w;
    w = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        w[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return w;
  endfunction : lane_merge

  // Cause bits raised by a rounding step, priority ordered
  function automatic logic [5:0] round_cause(input ftfc_step_t s, input logic fz);
    logic [5:0] c;
    logic dn;
    c = 6'h00;
    dn = s.denorm_in && s.affected;
    if (s.unimpl || (dn && !fz)) begin
      c[FTFC_CB_E] = 1'b1;
    end else if (s.invalid) begin
      c[FTFC_CB_V] = 1'b1;
      c[FTFC_CB_I] = dn;
    end else if (s.div_zero) begin
      c[FTFC_CB_Z] = 1'b1;
    end else begin
      c[FTFC_CB_I] = s.inexact || dn;
      c[FTFC_CB_O] = s.ovf;
      c[FTFC_CB_U] = s.tiny && !s.ovf;
    end
    return c;
  endfunction : round_cause

  // Forced value of a tiny result under flush-to-zero
  function automatic ftfc_cls_t tiny_default(input ftfc_rm_t rm, input logic neg);
    ftfc_cls_t cl;
    cl = FTFC_RES_ZERO;
    if ((rm == FTFC_RM_PLUS && !neg) || (rm == FTFC_RM_MINUS && neg)) begin
      cl = FTFC_RES_MIN_NORMAL;
    end
    return cl;
  endfunction : tiny_default

  // Flushing step: substitution and its cause bits
  // Limitation: operand zeroing happens in the arithmetic; this block only
  // decides the substituted class and the cause bits that go with it
  function automatic ftfc_flush_t flush_step(input ftfc_step_t s, input logic product,
                                             input ftfc_ctl_t ctl);
    ftfc_flush_t f;
    f.cause = 6'h00;
    f.cls = FTFC_RES_KEEP;
    if (s.ovf) begin
      f.cause[FTFC_CB_I] = 1'b1;
      f.cls = FTFC_RES_OVF_DEFAULT;
    end else if (s.tiny && s.affected) begin
      if (product && ctl.flush_override) begin
        f.cls = FTFC_RES_INTERNAL;
      end else if (!product && ctl.flush_nearest_ctl && ctl.rm == FTFC_RM_NEAREST) begin
        f.cls = s.below_half ? FTFC_RES_ZERO : FTFC_RES_MIN_NORMAL;
        f.cause[FTFC_CB_I] = 1'b1;
      end else if (ctl.flush_zero_ctl || (!product && ctl.flush_nearest_ctl)) begin
        f.cls = tiny_default(ctl.rm, s.sign);
        f.cause[FTFC_CB_I] = 1'b1;
      end else begin
        f.cause[FTFC_CB_E] = 1'b1;
      end
    end
    return f;
  endfunction : flush_step

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ftfc_state_t state;
  ftfc_state_t next_state;
  ftfc_req_t req_q;
  ftfc_rm_t rm;
  logic flush_zero_ctl;
  logic flush_override;
  logic flush_nearest_ctl;
  logic [4:0] enables;
  logic [5:0] cause;
  logic [4:0] flags;
  logic last_trap;

  // --------------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------------
  logic setup;
  logic access;
  logic csr_hit;
  logic st_hit;
  logic mode_hit;
  logic bad_acc;
  logic csr_wr;
  logic mode_wr;
  logic [31:0] csr_rd;
  logic [31:0] mode_rd;
  logic [31:0] st_rd;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic [5:0] wcause;
  logic [4:0] wen;
  logic wr_trap_now;

  // Zero-wait slave: data is staged in setup, so pready rises in the access cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign csr_hit = paddr == FTFC_CSR_OFS;
  assign st_hit = paddr == FTFC_STATUS_OFS;
  assign mode_hit = paddr == FTFC_MODE_OFS;
  assign bad_acc = !(csr_hit || st_hit || mode_hit) || (pwrite && st_hit);
  assign csr_wr = access && pwrite && csr_hit;
  assign mode_wr = access && pwrite && mode_hit;

  // Read views; reserved bits read zero
  assign csr_rd = {7'h00, flush_zero_ctl, 1'b0, flush_override, flush_nearest_ctl, 3'h0,
                   cause, enables, flags, rm};
  assign mode_rd = {7'h00, flush_zero_ctl, 1'b0, flush_override, flush_nearest_ctl, 19'h0, rm};
  assign st_rd = {26'h0, op_res.sign, op_res.cls, last_trap, state != FTFC_IDLE};
  assign rd_mux = csr_hit ? csr_rd : (mode_hit ? mode_rd : (st_hit ? st_rd : 32'h0));
  assign wr_word = lane_merge(csr_hit ? csr_rd : mode_rd, pwdata, pstrb);
  assign wcause = wr_word[FTFC_CAUSE_LSB +: 6];
  assign wen = wr_word[FTFC_EN_LSB +: 5];

  // A move into either control view checks the resulting enables and cause
  assign wr_trap_now = csr_wr ? (wcause[FTFC_CB_E] || |(wcause[4:0] & wen))
                     : (mode_wr && (cause[FTFC_CB_E] || |(cause[4:0] & enables)));

  // --------------------------------------------------------------------------
  // Cause sequencer datapath
  // --------------------------------------------------------------------------
  ftfc_ctl_t ctl;
  ftfc_step_t cur_step;
  ftfc_flush_t cur_flush;
  logic step_active;
  logic is_round;
  logic in_a;
  logic accept;
  logic [5:0] step_cause;
  logic [5:0] merged;
  logic step_trap;
  logic finish;
  logic [5:0] next_cause;
  logic [4:0] next_flags;

  assign ctl = '{rm: rm, flush_zero_ctl: flush_zero_ctl, flush_override: flush_override,
                 flush_nearest_ctl: flush_nearest_ctl, enables: enables};
  assign step_active = state != FTFC_IDLE;
  assign is_round = state == FTFC_RND_A || state == FTFC_RND_B;
  assign in_a = state == FTFC_RND_A || state == FTFC_FLS_A;
  assign accept = op_valid && op_ready;
  // Addend conditions live in step_b, so they appear only in the sum rounding step
  assign cur_step = in_a ? req_q.step_a : req_q.step_b;
  assign cur_flush = flush_step(cur_step, state == FTFC_FLS_A, ctl);
  assign step_cause = !step_active ? 6'h00
                    : (is_round ? round_cause(cur_step, flush_zero_ctl) : cur_flush.cause);
  // Unimplemented wipes whatever earlier steps left
  assign merged = step_cause[FTFC_CB_E] ? FTFC_CAUSE_E_ONLY : (cause | step_cause);
  // Unimplemented has no enable bit and always traps
  assign step_trap = step_active && (step_cause[FTFC_CB_E] || |(step_cause[4:0] & enables));
  assign finish = step_active && (step_trap || state == FTFC_FLS_B);

  // Hardware update beats a software write to the same cause bits
  assign next_cause = step_active ? merged
                    : (accept ? 6'h00 : (csr_wr ? wcause : cause));
  // Flags collect only untrapped completions; set wins over a clearing write
  assign next_flags = (csr_wr ? wr_word[FTFC_FLAGS_LSB +: 5] : flags)
                    | ((state == FTFC_FLS_B && !step_trap) ? merged[4:0] : 5'h00);

  // Step order; a trap ends the operation in the step that raised it
  always_comb begin
    next_state = state;
    unique case (state)
      FTFC_IDLE: begin
        if (accept) begin
          next_state = op_req.fma ? FTFC_RND_A : FTFC_RND_B;
        end
      end
      FTFC_RND_A: begin
        next_state = step_trap ? FTFC_IDLE : FTFC_FLS_A;
      end
      FTFC_FLS_A: begin
        next_state = step_trap ? FTFC_IDLE : FTFC_RND_B;
      end
      FTFC_RND_B: begin
        next_state = step_trap ? FTFC_IDLE : FTFC_FLS_B;
      end
      FTFC_FLS_B: begin
        next_state = FTFC_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------------------
  // Sequencer state and pipeline handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FTFC_IDLE;
      req_q <= '0;
      op_ready <= 1'b1;
      op_done <= 1'b0;
      op_trap <= 1'b0;
      op_res <= '{cls: FTFC_RES_KEEP, sign: 1'b0};
      last_trap <= 1'b0;
    end else begin
      state <= next_state;
      op_ready <= next_state == FTFC_IDLE;
      op_done <= finish;
      op_trap <= step_trap;
      if (accept) begin
        req_q <= op_req;
      end
      if (finish) begin
        last_trap <= step_trap;
      end
      if (state == FTFC_FLS_B) begin
        op_res <= '{cls: cur_flush.cls, sign: cur_step.sign};
      end
    end
  end

  // Control and status fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rm <= ftfc_rm_t'(FTFC_CSR_RST[FTFC_RM_LSB +: 2]);
      flush_zero_ctl <= FTFC_CSR_RST[FTFC_FLUSH_ZERO_BIT];
      flush_override <= FTFC_CSR_RST[FTFC_FLUSH_OVR_BIT];
      flush_nearest_ctl <= FTFC_CSR_RST[FTFC_FLUSH_NEAR_BIT];
      enables <= FTFC_CSR_RST[FTFC_EN_LSB +: 5];
      cause <= FTFC_CSR_RST[FTFC_CAUSE_LSB +: 6];
      flags <= FTFC_CSR_RST[FTFC_FLAGS_LSB +: 5];
      move_trap <= 1'b0;
    end else begin
      cause <= next_cause;
      flags <= next_flags;
      move_trap <= wr_trap_now;
      if (csr_wr || mode_wr) begin
        rm <= ftfc_rm_t'(wr_word[FTFC_RM_LSB +: 2]);
        flush_zero_ctl <= wr_word[FTFC_FLUSH_ZERO_BIT];
        flush_override <= wr_word[FTFC_FLUSH_OVR_BIT];
        flush_nearest_ctl <= wr_word[FTFC_FLUSH_NEAR_BIT];
      end
      if (csr_wr) begin
        enables <= wen;
      end
    end
  end

  // Bus answer, staged in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && bad_acc;
      prdata <= (setup && !pwrite && !bad_acc) ? rd_mux : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking ast_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_UNIMPL_ALONE: assert property (
    step_cause[FTFC_CB_E] |=> cause == FTFC_CAUSE_E_ONLY && op_trap && op_done)
    else $error("unimplemented cause not left alone");

  AST_TRAP_STOPS: assert property (
    step_trap |=> state == FTFC_IDLE && op_trap && op_ready ##1 !op_done)
    else $error("trap did not end the operation");

  AST_NO_UO_ROUND: assert property (
    is_round |-> !(step_cause[FTFC_CB_U] && step_cause[FTFC_CB_O]))
    else $error("underflow and overflow in one rounding step");

  AST_EVZ_EXCL: assert property (
    is_round && |step_cause[5:3] |-> $onehot(step_cause[5:3]) && step_cause[2:1] == 2'b00
      && (!step_cause[FTFC_CB_I] || step_cause[FTFC_CB_V]))
    else $error("priority cause mixed with others");

  AST_FLUSH_INEXACT: assert property (
    step_active && !is_round && cur_flush.cls inside {FTFC_RES_ZERO, FTFC_RES_MIN_NORMAL,
      FTFC_RES_OVF_DEFAULT} |-> step_cause[FTFC_CB_I])
    else $error("default substituted without inexact");

  AST_FO_KEEP: assert property (
    state == FTFC_FLS_A && flush_override && req_q.step_a.tiny && req_q.step_a.affected
      && !req_q.step_a.ovf |-> !step_cause[FTFC_CB_E] && cur_flush.cls == FTFC_RES_INTERNAL)
    else $error("overridden product was flushed or trapped");

  AST_FMA_ORDER: assert property (
    accept && op_req.fma |=> state == FTFC_RND_A ##1 (state == FTFC_FLS_A || op_done))
    else $error("fused steps out of order");

  AST_MOVE_TRAP: assert property (
    csr_wr && wcause[FTFC_CB_E] |=> move_trap)
    else $error("move with unimplemented cause did not trap");

  AST_NEAREST: assert property (
    state == FTFC_FLS_B && req_q.step_b.tiny && req_q.step_b.affected && !req_q.step_b.ovf
      && flush_nearest_ctl && rm == FTFC_RM_NEAREST
      |=> op_res.cls == ($past(req_q.step_b.below_half) ? FTFC_RES_ZERO : FTFC_RES_MIN_NORMAL)
        && op_res.sign == $past(req_q.step_b.sign))
    else $error("flush to nearest gave wrong value");

  AST_FS_DENORM_I: assert property (
    is_round && flush_zero_ctl && cur_step.denorm_in && cur_step.affected && !cur_step.unimpl
      |-> step_cause[FTFC_CB_I])
    else $error("flushed denormal operand without inexact");

  AST_DENORM_E: assert property (
    is_round && !flush_zero_ctl && cur_step.denorm_in && cur_step.affected
      |-> step_cause[FTFC_CB_E])
    else $error("unflushed denormal operand did not raise unimplemented");

  AST_FZ_FINAL: assert property (
    state == FTFC_FLS_B && flush_zero_ctl && !flush_nearest_ctl && cur_step.affected
      && cur_step.tiny && !cur_step.ovf |-> !step_cause[FTFC_CB_E]
      && cur_flush.cls inside {FTFC_RES_ZERO, FTFC_RES_MIN_NORMAL})
    else $error("flush to zero trapped or kept a tiny result");

  AST_FLAGS_HOLD: assert property (
    step_trap && !csr_wr |=> flags == $past(flags))
    else $error("trapped operation changed the flags");

  AST_ACCEPT_CLEAR: assert property (
    accept |=> cause == 6'h00)
    else $error("cause not cleared when an operation was taken");

  AST_MODE_MOVE: assert property (
    mode_wr && |(cause[4:0] & enables) |=> move_trap)
    else $error("mode move with enabled cause did not trap");

  COV_FMA_CLEAN: cover property (accept && op_req.fma ##5 op_done && !op_trap);
  COV_FO_KEEP: cover property (state == FTFC_FLS_A && cur_flush.cls == FTFC_RES_INTERNAL);
  COV_ORD_TRAP: cover property (accept && !op_req.fma ##[1:2] op_trap);
  COV_MOVE_TRAP: cover property (move_trap);
  COV_UO_BOTH: cover property (op_done && !op_trap && flags[FTFC_CB_U] && flags[FTFC_CB_O]);

endmodule : ftfc_core
`default_nettype wire

// ===== verification/ftfc_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pipeline model: offers one operation, reports its outcome
// ----------------------------------------------------------------------------
module ftfc_pipe_model
  import ftfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire ftfc_req_t req,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic op_trap,
  input wire ftfc_res_t op_res,
  output logic op_valid,
  output ftfc_req_t op_req,
  output logic fin,
  output logic fin_trap,
  output ftfc_res_t fin_res
);
  // Request held until taken; afterwards the payload is scrambled
  // so that a design sampling it late sees junk, not a stale copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid <= 1'b0;
      op_req <= '0;
      fin <= 1'b0;
      fin_trap <= 1'b0;
      fin_res <= '0;
    end else begin
      fin <= op_done;
      if (op_done) begin
        fin_trap <= op_trap;
        fin_res <= op_res;
      end
      if (go) begin
        op_valid <= 1'b1;
        op_req <= req;
      end else if (op_valid && op_ready) begin
        op_valid <= 1'b0;
        op_req <= ftfc_req_t'(~op_req);
      end
    end
  end
endmodule : ftfc_pipe_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ftfc_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [FTFC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, op_valid, op_ready, op_done, op_trap, move_trap;
  logic go = 1'b0, fin, fin_trap;
  ftfc_req_t req = '0, op_req;
  ftfc_res_t op_res, fin_res;
  int n_fail = 0, comparisons = 0;
  localparam logic [31:0] FLUSH_Z = 32'h1 << FTFC_FLUSH_ZERO_BIT;
  localparam logic [31:0] FLUSH_OV = 32'h1 << FTFC_FLUSH_OVR_BIT;
  localparam logic [31:0] FLUSH_NR = 32'h1 << FTFC_FLUSH_NEAR_BIT;

  always #2.5 pclk = ~pclk;

  ftfc_core i_ftfc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req),
    .op_ready(op_ready), .op_done(op_done), .op_trap(op_trap), .move_trap(move_trap),
    .op_res(op_res));
  ftfc_pipe_model i_ftfc_pipe_model (.pclk(pclk), .presetn(presetn), .go(go), .req(req),
    .op_ready(op_ready), .op_done(op_done), .op_trap(op_trap), .op_res(op_res),
    .op_valid(op_valid), .op_req(op_req), .fin(fin), .fin_trap(fin_trap), .fin_res(fin_res));

  // --------------------------------------------------------------------------
  // Compare, bus and operation tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_res(input ftfc_res_t g, input ftfc_res_t e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: result got %h expected %h", $time, g, e);
    end
  endtask : chk_res
  // Idle cycle first, so no signal is driven twice in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cause_is(input logic [5:0] e);
    apb(1'b0, FTFC_CSR_OFS, 32'h0);
    chk(rdat[FTFC_CAUSE_LSB +: 6], e);
  endtask : cause_is
  task automatic op_chk(input logic f, input logic [9:0] a, input logic [9:0] b,
                        input logic et, input ftfc_cls_t ec, input logic es);
    @(posedge pclk);
    go <= 1'b1;
    req <= ftfc_req_t'({f, a, b});
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (fin !== 1'b1);
    chk(fin_trap, et);
    if (!et) chk_res(fin_res, ftfc_res_t'({ec, es}));
  endtask : op_chk
  function automatic ftfc_cls_t fz(input logic [1:0] rm, input logic s);
    // Directed modes round a tiny value away from zero on their own side
    return ((rm == 2'h2 && !s) || (rm == 2'h3 && s)) ? FTFC_RES_MIN_NORMAL : FTFC_RES_ZERO;
  endfunction : fz

  task automatic test_done();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FTFC_CSR_OFS, 32'h0);
    chk(rdat, FTFC_CSR_RST);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, FTFC_STATUS_OFS, 32'hffff_ffff);
    chk(rerr, 1'b1);
    $display("test reset_and_refusal done");
    // Flush-to-zero table over all rounding modes and both signs
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, FTFC_CSR_OFS, FLUSH_Z | 32'(i >> 1));
      op_chk(1'b0, 10'h000, 10'h204 | 10'(i & 1), 1'b0, fz(2'(i >> 1), 1'(i)), 1'(i));
      cause_is(6'h03);
    end
    // Overflow with tiny: only overflow counts; a flushed denormal operand sets inexact
    op_chk(1'b0, 10'h000, 10'h20c, 1'b0, FTFC_RES_OVF_DEFAULT, 1'b0);
    cause_is(6'h05);
    op_chk(1'b0, 10'h000, 10'h300, 1'b0, FTFC_RES_KEEP, 1'b0);
    cause_is(6'h01);
    $display("test flush_zero done");
    apb(1'b1, FTFC_CSR_OFS, FLUSH_NR | FLUSH_Z);
    op_chk(1'b0, 10'h000, 10'h204, 1'b0, FTFC_RES_MIN_NORMAL, 1'b0);
    op_chk(1'b0, 10'h000, 10'h207, 1'b0, FTFC_RES_ZERO, 1'b1);
    apb(1'b0, FTFC_STATUS_OFS, 32'h0);
    chk(rdat, (32'h1 << FTFC_ST_SIGN) | (32'(FTFC_RES_ZERO) << FTFC_ST_CLS_LSB));
    apb(1'b1, FTFC_CSR_OFS, FLUSH_NR | 32'h2);
    op_chk(1'b0, 10'h000, 10'h204, 1'b0, FTFC_RES_MIN_NORMAL, 1'b0);
    $display("test flush_nearest done");
    apb(1'b1, FTFC_CSR_OFS, 32'h0);
    op_chk(1'b0, 10'h000, 10'h204, 1'b1, FTFC_RES_KEEP, 1'b0);
    cause_is(FTFC_CAUSE_E_ONLY);
    op_chk(1'b1, 10'h204, 10'h000, 1'b1, FTFC_RES_KEEP, 1'b0);
    cause_is(FTFC_CAUSE_E_ONLY);
    op_chk(1'b0, 10'h000, 10'h060, 1'b0, FTFC_RES_KEEP, 1'b0);
    cause_is(6'h10);
    $display("test unimplemented done");
    // Product kept by override, sum overflows: both range bits end up set
    apb(1'b1, FTFC_CSR_OFS, FLUSH_OV);
    op_chk(1'b1, 10'h204, 10'h208, 1'b0, FTFC_RES_OVF_DEFAULT, 1'b0);
    cause_is(6'h07);
    chk(rdat[FTFC_FLAGS_LSB +: 5], 5'h07);
    op_chk(1'b1, 10'h204, 10'h300, 1'b1, FTFC_RES_KEEP, 1'b0);
    cause_is(FTFC_CAUSE_E_ONLY);
    $display("test fused done");
    // Underflow enabled: trap in the rounding step, flags untouched
    apb(1'b1, FTFC_CSR_OFS, FLUSH_Z | (32'h1 << (FTFC_EN_LSB + FTFC_CB_U)));
    op_chk(1'b0, 10'h000, 10'h204, 1'b1, FTFC_RES_KEEP, 1'b0);
    cause_is(6'h02);
    chk(rdat[FTFC_FLAGS_LSB +: 5], 5'h00);
    $display("test enabled_trap done");
    apb(1'b1, FTFC_CSR_OFS, (32'h1 << FTFC_CAUSE_LSB) | (32'h1 << FTFC_EN_LSB));
    @(posedge pclk);
    chk(move_trap, 1'b1);
    apb(1'b1, FTFC_MODE_OFS, 32'h0);
    @(posedge pclk);
    chk(move_trap, 1'b1);
    apb(1'b1, FTFC_CSR_OFS, 32'h1 << (FTFC_CAUSE_LSB + FTFC_CB_E));
    @(posedge pclk);
    chk(move_trap, 1'b1);
    apb(1'b1, FTFC_CSR_OFS, 32'h0);
    @(posedge pclk);
    chk(move_trap, 1'b0);
    $display("test move_trap done");
    test_done();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
